// ### shared/pfc_pkg.sv
package pfc_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int DUAL_BIT = 1;
  localparam int SYNC_STAGES = 2;
  localparam int TIMER_W = 16;

  // ----------------------------------------------------------------
  // Timing, in nanoseconds and in cycles of ref_clk
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 20;
  localparam int T_RST_PULSE_NS = 1000;
  localparam int T_RST_RECOVER_NS = 1000;
  localparam int T_READ_ACCESS_NS = 110;
  localparam int T_WRITE_PULSE_NS = 100;

  // Least times round up to whole cycles and never fall below one.
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int RST_PULSE_CYC = cyc_min(T_RST_PULSE_NS);
  localparam int RST_RECOVER_CYC = cyc_min(T_RST_RECOVER_NS);
  localparam int READ_CYC = cyc_min(T_READ_ACCESS_NS) + SYNC_STAGES;
  localparam int WRITE_CYC = cyc_min(T_WRITE_PULSE_NS);

  // ----------------------------------------------------------------
  // Reset values and addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CFG_START_ADDR = 24'h000000;
  localparam logic [DATA_W-1:0] DATA_ALL_ONES = 16'hFFFF;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // Configuration schemes, as strapped on the scheme select pins
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACTIVE_SERIAL_SCHEME = 2'h0,
    PASSIVE_SERIAL_SCHEME = 2'h1,
    FAST_PASSIVE_PARALLEL_SCHEME = 2'h2,
    ACTIVE_PARALLEL_SCHEME = 2'h3
  } pfc_scheme_t;

endpackage

// ### design/pfc_sync.sv
`timescale 1ns/1ps

module pfc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_q;

  // Two stages; only the second stage reads the first.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      syncOut <= '0;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end

endmodule

// ### design/pfc_loader.sv
`timescale 1ns/1ps

module pfc_loader
  import pfc_pkg::*;
#(
  parameter int IMAGE_WORDS = 4096
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Scheme straps and status pins
  input wire logic [1:0] schemeSel,
  input wire logic wordWide,
  input wire logic extCfgDone,
  // Configuration stream
  output logic [DATA_W-1:0] cfgData,
  output logic cfgValid,
  output logic configDone,
  // User-mode access
  input wire logic userReq,
  input wire logic userWrite,
  input wire logic [ADDR_W-1:0] userAddr,
  input wire logic [DATA_W-1:0] userWdata,
  input wire logic [DATA_W-1:0] userPinOut,
  input wire logic [DATA_W-1:0] userPinOeN,
  output logic userAck,
  output logic [DATA_W-1:0] userRdata,
  // Flash control pins
  output logic [ADDR_W-1:0] flash_address_bus,
  output logic flash_reset_out_n,
  output logic flash_address_valid_n,
  output logic flash_output_enable_n,
  output logic flash_write_enable_n,
  output logic flash_chip_select_out,
  // Flash data pins
  input wire logic [DATA_W-1:0] flashDataIn,
  output logic [DATA_W-1:0] flashDataOut,
  output logic [DATA_W-1:0] flashDataOeN,
  input wire logic serial_data_out_dual_i,
  output logic serial_data_out_dual_o,
  output logic serial_data_out_dual_oe_n
);

  // The image length must fit the word address space.
  if (IMAGE_WORDS < 1 || IMAGE_WORDS > (1 << ADDR_W)) begin : g_bad_image_words
    $error("pfc_loader: IMAGE_WORDS out of range");
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int SYNC_W = DATA_W + 4;

  logic [DATA_W-1:0] rawData;
  logic [SYNC_W-1:0] syncBus;
  logic [DATA_W-1:0] dataSync;
  logic [1:0] schemeSync;
  logic wordWideSync;
  logic extDoneSync;

  pfc_sync #(.WIDTH(SYNC_W)) u_sync (
    .clk(ref_clk),
    .rst(rst),
    .asyncIn({rawData, schemeSel, wordWide, extCfgDone}),
    .syncOut(syncBus)
  );

  assign dataSync = syncBus[SYNC_W-1:4];
  assign schemeSync = syncBus[3:2];
  assign wordWideSync = syncBus[1];
  assign extDoneSync = syncBus[0];

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_STRAP, ST_RST_LOW, ST_RST_WAIT, ST_WAIT_EXT, ST_ADDR, ST_LATCH,
    ST_READ, ST_WR_DATA, ST_WR_PULSE, ST_RELEASE, ST_USER
  } pfc_state_t;

  pfc_state_t state_q, state_d;
  pfc_scheme_t scheme_q, scheme_d;
  logic wide_q, wide_d;
  logic [TIMER_W-1:0] cnt_q, cnt_d;
  logic [ADDR_W-1:0] words_q, words_d;
  logic isWrite_q, isWrite_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic rstN_q, rstN_d;
  logic avdN_q, avdN_d;
  logic oeN_q, oeN_d;
  logic weN_q, weN_d;
  logic ceN_q, ceN_d;
  logic [DATA_W-1:0] dOut_q, dOut_d;
  logic [DATA_W-1:0] dOeN_q, dOeN_d;
  logic dualOut_q, dualOut_d;
  logic dualOeN_q, dualOeN_d;
  logic [DATA_W-1:0] cfgData_q, cfgData_d;
  logic cfgValid_q, cfgValid_d;
  logic done_q, done_d;
  logic ack_q, ack_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic dualIsData;
  logic [DATA_W-1:0] sample;

  // The dual serial pin stands in for data line 1 in both parallel schemes.
  assign dualIsData = (scheme_q == ACTIVE_PARALLEL_SCHEME) ||
                      (scheme_q == FAST_PASSIVE_PARALLEL_SCHEME);
  assign rawData = {flashDataIn[DATA_W-1:DUAL_BIT+1],
                    dualIsData ? serial_data_out_dual_i : flashDataIn[DUAL_BIT],
                    flashDataIn[DUAL_BIT-1:0]};
  // Byte-wide images carry only lines 7 to 0; the upper byte reads as zero.
  assign sample = wide_q ? dataSync : {DATA_ZERO[DATA_W-1:BYTE_W], dataSync[BYTE_W-1:0]};

  always_comb begin
    state_d = state_q;
    scheme_d = scheme_q;
    wide_d = wide_q;
    cnt_d = cnt_q;
    words_d = words_q;
    isWrite_d = isWrite_q;
    addr_d = addr_q;
    rstN_d = rstN_q;
    avdN_d = avdN_q;
    oeN_d = oeN_q;
    weN_d = weN_q;
    ceN_d = ceN_q;
    dOut_d = dOut_q;
    dOeN_d = dOeN_q;
    dualOut_d = dualOut_q;
    dualOeN_d = dualOeN_q;
    cfgData_d = cfgData_q;
    cfgValid_d = 1'b0;
    done_d = done_q;
    ack_d = 1'b0;
    rdata_d = rdata_q;
    unique case (state_q)
      ST_STRAP: begin
        // Wait for the strap synchronisers to fill, then latch the scheme.
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == TIMER_W'(SYNC_STAGES)) begin
          scheme_d = pfc_scheme_t'(schemeSync);
          wide_d = wordWideSync;
          cnt_d = '0;
          if (pfc_scheme_t'(schemeSync) == ACTIVE_PARALLEL_SCHEME) begin
            rstN_d = 1'b0;
            state_d = ST_RST_LOW;
          end else begin
            state_d = ST_WAIT_EXT;
          end
        end
      end
      ST_RST_LOW: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == TIMER_W'(RST_PULSE_CYC - 1)) begin
          rstN_d = 1'b1;
          cnt_d = '0;
          state_d = ST_RST_WAIT;
        end
      end
      ST_RST_WAIT: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == TIMER_W'(RST_RECOVER_CYC - 1)) begin
          cnt_d = '0;
          addr_d = CFG_START_ADDR;
          words_d = '0;
          isWrite_d = 1'b0;
          ceN_d = 1'b0;
          avdN_d = 1'b0;
          state_d = ST_ADDR;
        end
      end
      ST_WAIT_EXT: begin
        // Other schemes load elsewhere; all data lines float meanwhile.
        dOeN_d = DATA_ALL_ONES;
        dualOeN_d = 1'b1;
        if (extDoneSync) begin
          state_d = ST_USER;
        end
      end
      ST_ADDR: begin
        // Address and address-valid have stood one cycle with chip enable.
        avdN_d = 1'b1;
        state_d = ST_LATCH;
        if (isWrite_q) begin
          weN_d = 1'b0;
          state_d = ST_WR_PULSE;
        end
      end
      ST_LATCH: begin
        oeN_d = 1'b0;
        cnt_d = '0;
        state_d = ST_READ;
      end
      ST_READ: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == TIMER_W'(READ_CYC - 1)) begin
          oeN_d = 1'b1;
          ceN_d = 1'b1;
          cnt_d = '0;
          state_d = ST_RELEASE;
          if (done_q) begin
            rdata_d = dataSync;
          end else begin
            cfgData_d = sample;
            cfgValid_d = 1'b1;
            words_d = words_q + 1'b1;
          end
        end
      end
      ST_WR_DATA: begin
        ceN_d = 1'b0;
        avdN_d = 1'b0;
        state_d = ST_ADDR;
      end
      ST_WR_PULSE: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == TIMER_W'(WRITE_CYC - 1)) begin
          weN_d = 1'b1;
          ceN_d = 1'b1;
          cnt_d = '0;
          state_d = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        // Data stays driven two cycles past write-enable for hold time.
        if (done_q) begin
          ack_d = 1'b1;
          state_d = ST_USER;
        end else if (words_q == ADDR_W'(IMAGE_WORDS)) begin
          done_d = 1'b1;
          state_d = ST_USER;
        end else begin
          addr_d = addr_q + 1'b1;
          ceN_d = 1'b0;
          avdN_d = 1'b0;
          state_d = ST_ADDR;
        end
      end
      ST_USER: begin
        done_d = 1'b1;
        // Pins return to user logic between flash accesses.
        dOut_d = userPinOut;
        dOeN_d = userPinOeN;
        dualOeN_d = 1'b1;
        if (userReq && scheme_q == ACTIVE_PARALLEL_SCHEME) begin
          addr_d = userAddr;
          isWrite_d = userWrite;
          if (userWrite) begin
            dOut_d = userWdata;
            dOeN_d = wide_q ? DATA_ZERO : {DATA_ALL_ONES[DATA_W-1:BYTE_W], DATA_ZERO[BYTE_W-1:0]};
            dOeN_d[DUAL_BIT] = 1'b1;
            dualOut_d = userWdata[DUAL_BIT];
            dualOeN_d = 1'b0;
            state_d = ST_WR_DATA;
          end else begin
            dOeN_d = DATA_ALL_ONES;
            ceN_d = 1'b0;
            avdN_d = 1'b0;
            state_d = ST_ADDR;
          end
        end else if (userReq) begin
          ack_d = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_STRAP;
      scheme_q <= ACTIVE_SERIAL_SCHEME;
      wide_q <= 1'b0;
      cnt_q <= '0;
      words_q <= '0;
      isWrite_q <= 1'b0;
      addr_q <= CFG_START_ADDR;
      rstN_q <= 1'b1;
      avdN_q <= 1'b1;
      oeN_q <= 1'b1;
      weN_q <= 1'b1;
      ceN_q <= 1'b1;
      dOut_q <= DATA_ZERO;
      dOeN_q <= DATA_ALL_ONES;
      dualOut_q <= 1'b0;
      dualOeN_q <= 1'b1;
      cfgData_q <= DATA_ZERO;
      cfgValid_q <= 1'b0;
      done_q <= 1'b0;
      ack_q <= 1'b0;
      rdata_q <= DATA_ZERO;
    end else begin
      state_q <= state_d;
      scheme_q <= scheme_d;
      wide_q <= wide_d;
      cnt_q <= cnt_d;
      words_q <= words_d;
      isWrite_q <= isWrite_d;
      addr_q <= addr_d;
      rstN_q <= rstN_d;
      avdN_q <= avdN_d;
      oeN_q <= oeN_d;
      weN_q <= weN_d;
      ceN_q <= ceN_d;
      dOut_q <= dOut_d;
      dOeN_q <= dOeN_d;
      dualOut_q <= dualOut_d;
      dualOeN_q <= dualOeN_d;
      cfgData_q <= cfgData_d;
      cfgValid_q <= cfgValid_d;
      done_q <= done_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign flash_address_bus = addr_q;
  assign flash_reset_out_n = rstN_q;
  assign flash_address_valid_n = avdN_q;
  assign flash_output_enable_n = oeN_q;
  assign flash_write_enable_n = weN_q;
  assign flash_chip_select_out = ceN_q;
  assign flashDataOut = dOut_q;
  assign flashDataOeN = dOeN_q;
  assign serial_data_out_dual_o = dualOut_q;
  assign serial_data_out_dual_oe_n = dualOeN_q;
  assign cfgData = cfgData_q;
  assign cfgValid = cfgValid_q;
  assign configDone = done_q;
  assign userAck = ack_q;
  assign userRdata = rdata_q;

endmodule

// ### testbench/pfc_loader_chk.sv
`timescale 1ns/1ps
module pfc_loader_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cfgValid,
  input wire logic configDone,
  input wire logic userAck,
  input wire logic [23:0] flash_address_bus,
  input wire logic flash_reset_out_n,
  input wire logic flash_address_valid_n,
  input wire logic flash_output_enable_n,
  input wire logic flash_write_enable_n,
  input wire logic flash_chip_select_out,
  input wire logic [15:0] flashDataOeN,
  input wire logic serial_data_out_dual_oe_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_avd_with_ce: assert property ($fell(flash_address_valid_n) |-> !flash_chip_select_out)
    else $error("address valid without chip enable");
  chk_oe_after_avd: assert property ($fell(flash_output_enable_n) |->
    $past(!flash_address_valid_n, 2) && !flash_chip_select_out)
    else $error("output enable out of order");
  chk_oe_width: assert property ($fell(flash_output_enable_n) |->
    !flash_output_enable_n [*5] ##1 flash_output_enable_n)
    else $error("output enable width wrong");
  chk_we_width: assert property ($fell(flash_write_enable_n) |->
    !flash_write_enable_n [*2] ##1 flash_write_enable_n)
    else $error("write enable width wrong");
  chk_we_data_on: assert property (!flash_write_enable_n |->
    flashDataOeN[7:2] == 6'h00 && !serial_data_out_dual_oe_n)
    else $error("write without driven data");
  chk_oe_no_drive: assert property (!flash_output_enable_n |-> flashDataOeN == 16'hFFFF)
    else $error("data driven during read");
  chk_cfg_tristate: assert property (!configDone |-> flashDataOeN == 16'hFFFF)
    else $error("data pins driven during configuration");
  chk_valid_at_end: assert property (cfgValid |->
    $rose(flash_output_enable_n) && $rose(flash_chip_select_out))
    else $error("word valid outside read end");
  chk_reset_pulse: assert property ($fell(flash_reset_out_n) |->
    ##19 !flash_reset_out_n ##1 flash_reset_out_n)
    else $error("flash reset pulse length wrong");
  chk_addr_steady: assert property (!flash_chip_select_out && $past(!flash_chip_select_out) |->
    $stable(flash_address_bus))
    else $error("address moved during access");
  chk_ack_pulse: assert property (userAck |=> !userAck)
    else $error("acknowledge longer than one cycle");
endmodule

bind pfc_loader pfc_loader_chk i_pfc_loader_chk (.ref_clk(ref_clk), .rst(rst), .cfgValid(cfgValid),
  .configDone(configDone), .userAck(userAck), .flash_address_bus(flash_address_bus),
  .flash_reset_out_n(flash_reset_out_n), .flash_address_valid_n(flash_address_valid_n),
  .flash_output_enable_n(flash_output_enable_n), .flash_write_enable_n(flash_write_enable_n),
  .flash_chip_select_out(flash_chip_select_out), .flashDataOeN(flashDataOeN),
  .serial_data_out_dual_oe_n(serial_data_out_dual_oe_n));

// ### testbench/pfc_flash_model.sv
`timescale 1ns/1ps
module pfc_flash_model #(
  parameter int LAT = 0
) (
  input wire logic clk,
  input wire logic [23:0] addr,
  input wire logic resetN,
  input wire logic ceN,
  input wire logic avdN,
  input wire logic oeN,
  input wire logic weN,
  input wire logic [15:0] bus,
  output logic [15:0] dq
);
  logic [15:0] mem [0:15];
  logic [15:0] lastQ = 16'h0000;
  logic [3:0] a = 4'h0;
  logic weQ = 1'b1;
  int cnt = 0;
  initial for (int i = 0; i < 16; i++) mem[i] = {8'(i) ^ 8'hC3, 8'(i) + 8'h10};
  // Released lines show a pattern that changes every cycle, never the last value.
  assign dq = (resetN && !ceN && !oeN && cnt >= LAT) ? mem[a] : ~lastQ;
  always @(posedge clk) begin
    lastQ <= dq;
    weQ <= weN;
    cnt <= oeN ? 0 : cnt + 1;
    if (!resetN) a <= 4'h0;
    else if (!avdN && !ceN) a <= addr[3:0];
    if (resetN && !weQ && weN) mem[a] <= bus;
  end
endmodule

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import pfc_pkg::*;
  localparam int NW = 4;
  logic ref_clk, rst, wordWide, extCfgDone, userReq, userWrite, cfgValid, configDone, userAck;
  logic [1:0] schemeSel;
  logic [ADDR_W-1:0] userAddr, flash_address_bus;
  logic [DATA_W-1:0] userWdata, userPinOut, userPinOeN, cfgData, userRdata;
  logic [DATA_W-1:0] flashDataOut, flashDataOeN, flashDataIn, memOut, line;
  logic flash_reset_out_n, flash_address_valid_n, flash_output_enable_n, flash_write_enable_n;
  logic flash_chip_select_out, dualO, dualOeN;
  logic [15:0] ref_mem [0:15];
  logic [23:0] addrQ [$];
  int num_errors, n_compared, n, seed;
  logic [3:0] a;
  logic [15:0] d;

  // The dual pin is data line 1 of the flash bus.
  always_comb begin
    for (int i = 0; i < 16; i++) line[i] = !flashDataOeN[i] ? flashDataOut[i] : memOut[i];
    line[1] = !dualOeN ? dualO : memOut[1];
  end
  assign flashDataIn = line;

  pfc_loader #(.IMAGE_WORDS(NW)) i_pfc_loader (.ref_clk(ref_clk), .rst(rst),
    .schemeSel(schemeSel), .wordWide(wordWide), .extCfgDone(extCfgDone), .cfgData(cfgData),
    .cfgValid(cfgValid), .configDone(configDone), .userReq(userReq), .userWrite(userWrite),
    .userAddr(userAddr), .userWdata(userWdata), .userPinOut(userPinOut),
    .userPinOeN(userPinOeN), .userAck(userAck), .userRdata(userRdata),
    .flash_address_bus(flash_address_bus), .flash_reset_out_n(flash_reset_out_n),
    .flash_address_valid_n(flash_address_valid_n), .flash_output_enable_n(flash_output_enable_n),
    .flash_write_enable_n(flash_write_enable_n), .flash_chip_select_out(flash_chip_select_out),
    .flashDataIn(flashDataIn), .flashDataOut(flashDataOut), .flashDataOeN(flashDataOeN),
    .serial_data_out_dual_i(line[1]), .serial_data_out_dual_o(dualO),
    .serial_data_out_dual_oe_n(dualOeN));

  pfc_flash_model #(.LAT(2)) i_pfc_flash_model (.clk(ref_clk), .addr(flash_address_bus),
    .resetN(flash_reset_out_n), .ceN(flash_chip_select_out), .avdN(flash_address_valid_n),
    .oeN(flash_output_enable_n), .weN(flash_write_enable_n), .bus(line), .dq(memOut));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
    if (rst === 1'b0 && !flash_address_valid_n && !flash_chip_select_out)
      addrQ.push_back(flash_address_bus);

  task automatic cmp_val(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic ok);
    cmp_val(24'(ok), 24'h1);
  endtask

  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic restart(input logic [1:0] s, input logic ww);
    @(posedge ref_clk);
    rst <= 1'b1;
    schemeSel <= s;
    wordWide <= ww;
    extCfgDone <= 1'b0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    addrQ.delete();
  endtask

  task automatic wait_done;
    n = 0;
    while (configDone !== 1'b1 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    cmp_flag(configDone === 1'b1);
  endtask

  task automatic cfg_ap(input logic ww);
    for (int k = 0; k < NW; k++) begin
      n = 0;
      while (cfgValid !== 1'b1 && n < 400) begin
        @(negedge ref_clk);
        n++;
      end
      cmp_flag(cfgValid === 1'b1);
      cmp_val(24'(cfgData), 24'(ww ? ref_mem[k] : {8'h00, ref_mem[k][7:0]}));
      @(negedge ref_clk);
    end
    wait_done;
    for (int k = 0; k < NW; k++) cmp_val(addrQ[k], 24'(k));
  endtask

  task automatic cfg_other;
    repeat (40) @(negedge ref_clk);
    cmp_val(24'(flashDataOeN), 24'hFFFF);
    @(posedge ref_clk);
    extCfgDone <= 1'b1;
    wait_done;
    cmp_flag(addrQ.size() == 0);
  endtask

  task automatic user_op(input logic wr, input logic [3:0] ua, input logic [15:0] wd);
    @(posedge ref_clk);
    userReq <= 1'b1;
    userWrite <= wr;
    userAddr <= 24'(ua);
    userWdata <= wd;
    @(posedge ref_clk);
    userReq <= 1'b0;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (userAck !== 1'b1 && n < 50);
    cmp_flag(userAck === 1'b1);
    if (schemeSel != 2'h3) cmp_flag(n <= 2 && addrQ.size() == 0);
    else if (wr) ref_mem[ua] = wd;
    else cmp_val(24'(userRdata), 24'(ref_mem[ua]));
  endtask

  initial begin
    {rst, wordWide, extCfgDone, userReq, userWrite} = 5'b10000;
    schemeSel = 2'h0;
    userAddr = '0;
    userWdata = '0;
    userPinOut = '0;
    userPinOeN = 16'hFFFF;
    num_errors = 0;
    n_compared = 0;
    seed = $urandom(66);
    for (int k = 0; k < 16; k++) ref_mem[k] = {8'(k) ^ 8'hC3, 8'(k) + 8'h10};
    for (int s = 0; s < 4; s++) begin
      restart(2'(s), 1'b1);
      if (s == 3) cfg_ap(1'b1);
      else cfg_other;
      user_op(1'b0, 4'h5, 16'h0000);
      $display("test scheme %0d done", s);
    end
    @(posedge ref_clk);
    userPinOeN <= 16'($urandom);
    userPinOut <= 16'($urandom);
    repeat (3) @(negedge ref_clk);
    cmp_val(24'(flashDataOeN[15:2]), 24'(userPinOeN[15:2]));
    cmp_val(24'(flashDataOut), 24'(userPinOut));
    for (int i = 0; i < 3; i++) begin
      a = 4'($urandom);
      d = 16'($urandom);
      user_op(1'b1, a, d);
      user_op(1'b0, a, 16'h0000);
      user_op(1'b0, a ^ 4'h1, 16'h0000);
    end
    $display("test user access done");
    restart(2'h3, 1'b0);
    cfg_ap(1'b0);
    $display("test byte image done");
    close_out;
  end

  initial begin
    #(50 * 20000);
    num_errors++;
    close_out;
  end
endmodule
